// >>> opm_defs.vh
// Constants for the operating-mode sequencer.
// Assumes a 100 MHz system clock; included by opm_mode_ctrl.v.
`ifndef OPM_DEFS_VH
`define OPM_DEFS_VH
`define OPM_MODE_STOP 2'h0
`define OPM_MODE_STARTUP 2'h1
`define OPM_MODE_RUN 2'h2
`define OPM_MODE_HOLD 2'h3
`define OPM_CLK_HZ 100000000
`define OPM_BLINK_MIN_MS 3000
`define OPM_WDOG_MS 100
`define OPM_BLINK_HALF_MS 250
`define OPM_BP_COUNT 3
`define OPM_BP_STEP_MAX 2
`endif

// >>> opm_bp_table.v
// Breakpoint table: three entries of address and valid flag.
// Assumes the programming tool writes one entry per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "opm_defs.vh"
module opm_bp_table #(
  parameter AW = 16,
  parameter N = `OPM_BP_COUNT
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Tool side
  input wire wr_en,
  input wire [1:0] wr_idx,
  input wire wr_set,
  input wire [AW-1:0] wr_addr,
  input wire clr_all,
  // Lookup
  input wire [AW-1:0] pc,
  input wire bp_enable,
  output reg hit,
  output reg [1:0] count
);
  reg [AW-1:0] addr [0:N-1];
  reg [N-1:0] valid;
  wire [N-1:0] match;
  integer k;
  reg [1:0] next_count;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ent
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          addr[g] <= {AW{1'b0}};
          valid[g] <= 1'b0;
        end else if (clr_all) begin
          valid[g] <= 1'b0;
        end else if (wr_en && wr_idx == g) begin
          addr[g] <= wr_addr;
          valid[g] <= wr_set;
        end
      end
      assign match[g] = valid[g] && addr[g] == pc;
    end
  endgenerate
  always @* begin
    next_count = 2'h0;
    for (k = 0; k < N; k = k + 1)
      next_count = next_count + {1'b0, valid[k]};
  end
  // Registered lookup result and population count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hit <= 1'b0;
      count <= 2'h0;
    end else begin
      hit <= bp_enable && (|match);
      count <= next_count;
    end
  end
endmodule // opm_bp_table
`default_nettype wire

// >>> opm_mode_ctrl.v
// Operating-mode sequencer: stop, start-up, run and hold with indicators.
// Assumes the execution engine reports routine progress on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "opm_defs.vh"
module opm_mode_ctrl #(
  parameter AW = 16,
  parameter CLK_HZ = `OPM_CLK_HZ,
  parameter BLINK_MIN_CYC = (`OPM_CLK_HZ / 1000) * `OPM_BLINK_MIN_MS,
  parameter WDOG_CYC = (`OPM_CLK_HZ / 1000) * `OPM_WDOG_MS,
  parameter BLINK_HALF_CYC = (`OPM_CLK_HZ / 1000) * `OPM_BLINK_HALF_MS
) (
  // Clock and reset
  input wire CLOCK,
  input wire SYS_RST,
  // Mode requests
  input wire RUN_REQ,
  input wire STOP_REQ,
  input wire MEM_RESET,
  input wire PROJECT_RELOAD,
  input wire COLD_START_PRESENT,
  // Execution engine
  input wire STARTUP_DONE,
  input wire CYCLE_END,
  input wire WDOG_KICK,
  input wire CYCLE_TIMEOUT,
  input wire [AW-1:0] EXEC_PC,
  output wire STARTUP_ROUTINE_GO,
  output wire COLD_START_ROUTINE_GO,
  output wire MAIN_CYCLE_ROUTINE_GO,
  output wire EXEC_ENABLE,
  output wire TIMERS_RUN,
  output reg IMAGE_REFRESH,
  output wire CYCLE_SUPERVISE,
  // Programming tool
  input wire BP_WR,
  input wire [1:0] BP_IDX,
  input wire BP_SET,
  input wire [AW-1:0] BP_ADDR,
  input wire BP_CLR_ALL,
  input wire BP_ACTIVE,
  input wire STEP_REQ,
  input wire RESUME_REQ,
  output wire STEP_GO,
  output wire [1:0] BP_COUNT,
  output wire STEP_ALLOWED,
  // Status and pins
  output reg [1:0] MODE,
  output reg OUTPUT_LOCK,
  output reg RUN_LED,
  output reg STOP_LED,
  output reg WDOG_FAULT,
  output reg CYCLE_FAULT
);
  localparam S_STOP = `OPM_MODE_STOP;
  localparam S_STARTUP = `OPM_MODE_STARTUP;
  localparam S_RUN = `OPM_MODE_RUN;
  localparam S_HOLD = `OPM_MODE_HOLD;
  localparam [31:0] BLINK_MIN = BLINK_MIN_CYC;
  localparam [31:0] WDOG_LIM = WDOG_CYC;
  localparam [31:0] HALF_LIM = BLINK_HALF_CYC;

  reg [1:0] next_mode;
  reg wdog_block;
  reg cold_start;
  reg startup_busy;
  reg [31:0] blink_cnt;
  reg [31:0] half_cnt;
  reg [31:0] wdog_cnt;
  reg blink_phase;
  reg step_pending;
  reg [AW-1:0] step_pc;
  wire bp_hit;
  wire step_done;
  wire enter_startup;
  wire leave_startup;
  wire half_tick;
  wire in_startup;
  wire in_run;
  wire in_hold;
  wire blink_active;
  wire wdog_trip;
  wire step_ok;
  wire start_ok;

  opm_bp_table #(
    .AW(AW),
    .N(`OPM_BP_COUNT)
  ) u_bp (
    .clk(CLOCK),
    .rst(SYS_RST),
    .wr_en(BP_WR),
    .wr_idx(BP_IDX),
    .wr_set(BP_SET),
    .wr_addr(BP_ADDR),
    .clr_all(BP_CLR_ALL),
    .pc(EXEC_PC),
    .bp_enable(BP_ACTIVE),
    .hit(bp_hit),
    .count(BP_COUNT)
  );

  // Single step is refused once more than two breakpoints are defined
  assign step_ok = BP_COUNT <= `OPM_BP_STEP_MAX;
  assign STEP_ALLOWED = step_ok;
  assign STEP_GO = in_hold && STEP_REQ && step_ok && !STOP_REQ;
  // Watchdog restart needs the cold-start routine to exist
  assign start_ok = !wdog_block || COLD_START_PRESENT;
  assign wdog_trip = (MODE == S_RUN) && (wdog_cnt >= WDOG_LIM - 32'h1) && !WDOG_KICK;
  assign enter_startup = (MODE == S_STOP) && (next_mode == S_STARTUP);
  assign leave_startup = (MODE == S_STARTUP) && (next_mode == S_RUN);
  // A granted step ends once the engine has moved off the held statement
  assign step_done = step_pending && (EXEC_PC != step_pc);

  // Mode transitions
  always @* begin
    next_mode = MODE;
    case (MODE)
      S_STOP: begin
        if (RUN_REQ && !STOP_REQ && start_ok)
          next_mode = S_STARTUP;
      end
      S_STARTUP: begin
        if (STOP_REQ)
          next_mode = S_STOP;
        else if (STARTUP_DONE && startup_busy)
          next_mode = S_RUN;
      end
      S_RUN: begin
        if (STOP_REQ || wdog_trip || CYCLE_TIMEOUT)
          next_mode = S_STOP;
        // A granted single step returns to hold after one statement
        else if (bp_hit || step_done)
          next_mode = S_HOLD;
      end
      S_HOLD: begin
        if (STOP_REQ)
          next_mode = S_STOP;
        else if (RESUME_REQ || STEP_GO)
          next_mode = S_RUN;
      end
      default: next_mode = S_STOP;
    endcase
  end

  // Mode register
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      MODE <= S_STOP;
    else
      MODE <= next_mode;
  end

  // Start-up bookkeeping; a restart after a watchdog trip takes the cold-start routine
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      startup_busy <= 1'b0;
      cold_start <= 1'b0;
    end else if (enter_startup) begin
      startup_busy <= 1'b1;
      cold_start <= wdog_block;
    end else if (MODE != S_STARTUP || next_mode != S_STARTUP) begin
      startup_busy <= 1'b0;
    end
  end

  // Watchdog restart block; a trip wins over a simultaneous clearing event
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wdog_block <= 1'b0;
      WDOG_FAULT <= 1'b0;
    end else if (wdog_trip) begin
      wdog_block <= 1'b1;
      WDOG_FAULT <= 1'b1;
    end else if (MEM_RESET || PROJECT_RELOAD) begin
      wdog_block <= 1'b0;
      WDOG_FAULT <= 1'b0;
    end else if (leave_startup) begin
      wdog_block <= 1'b0;
      WDOG_FAULT <= 1'b0;
    end
  end

  // Cycle supervision fault, raised in run only
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      CYCLE_FAULT <= 1'b0;
    else if (MODE == S_RUN && CYCLE_TIMEOUT)
      CYCLE_FAULT <= 1'b1;
    else if (enter_startup)
      CYCLE_FAULT <= 1'b0;
  end

  // Single step: remember the held statement until the engine leaves it
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      step_pending <= 1'b0;
      step_pc <= {AW{1'b0}};
    end else if (STEP_GO) begin
      step_pending <= 1'b1;
      step_pc <= EXEC_PC;
    end else if (MODE != S_RUN || step_done || bp_hit) begin
      step_pending <= 1'b0;
    end
  end

  // Watchdog counter, restarted by each kick or cycle end
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      wdog_cnt <= 32'h0;
    else if (MODE != S_RUN || WDOG_KICK || CYCLE_END)
      wdog_cnt <= 32'h0;
    else if (wdog_cnt < WDOG_LIM)
      wdog_cnt <= wdog_cnt + 32'h1;
  end

  // Minimum blink window measured from start-up begin
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      blink_cnt <= 32'h0;
    else if (MODE == S_STOP && next_mode == S_STARTUP)
      blink_cnt <= BLINK_MIN;
    else if (blink_cnt != 32'h0)
      blink_cnt <= blink_cnt - 32'h1;
  end
  // Blink keeps going through start-up and hold
  assign blink_active = (blink_cnt != 32'h0) || (MODE == S_STARTUP) || (MODE == S_HOLD);

  // Blink phase divider: one-cycle enable at each half period
  assign half_tick = blink_active && (half_cnt >= HALF_LIM - 32'h1);
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      half_cnt <= 32'h0;
      blink_phase <= 1'b0;
    end else if (!blink_active) begin
      half_cnt <= 32'h0;
      blink_phase <= 1'b0;
    end else if (half_tick) begin
      half_cnt <= 32'h0;
      blink_phase <= ~blink_phase;
    end else begin
      half_cnt <= half_cnt + 32'h1;
    end
  end

  // Output lock and process image refresh
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OUTPUT_LOCK <= 1'b1;
      IMAGE_REFRESH <= 1'b0;
    end else begin
      OUTPUT_LOCK <= next_mode != S_RUN;
      // A cycle finished in run is written out even when run ends at that edge
      IMAGE_REFRESH <= in_run && CYCLE_END;
    end
  end

  // Indicators
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RUN_LED <= 1'b0;
      STOP_LED <= 1'b1;
    end else begin
      case (next_mode)
        S_STOP: begin
          RUN_LED <= (blink_cnt > 32'h1) ? ~blink_phase : 1'b0;
          STOP_LED <= 1'b1;
        end
        S_STARTUP: begin
          RUN_LED <= ~blink_phase;
          STOP_LED <= 1'b1;
        end
        S_RUN: begin
          RUN_LED <= (blink_cnt > 32'h1) ? ~blink_phase : 1'b1;
          STOP_LED <= 1'b0;
        end
        S_HOLD: begin
          RUN_LED <= ~blink_phase;
          STOP_LED <= 1'b1;
        end
        default: begin
          RUN_LED <= 1'b0;
          STOP_LED <= 1'b1;
        end
      endcase
    end
  end

  // Decoded mode
  assign in_startup = (MODE == S_STARTUP);
  assign in_run = (MODE == S_RUN);
  assign in_hold = (MODE == S_HOLD);
  // Engine controls; held process values are untouched in stop and hold
  assign STARTUP_ROUTINE_GO = in_startup && startup_busy && !cold_start;
  assign COLD_START_ROUTINE_GO = in_startup && startup_busy && cold_start;
  assign MAIN_CYCLE_ROUTINE_GO = in_run;
  assign EXEC_ENABLE = in_startup || in_run;
  assign TIMERS_RUN = in_run;
  assign CYCLE_SUPERVISE = in_run;
endmodule // opm_mode_ctrl
`default_nettype wire

// >>> opm_checker.sv
// Assertion checker for the operating-mode sequencer ports.
// Bound into opm_mode_ctrl; every signal shares CLOCK.
`timescale 1ns/1ps
`default_nettype none
module opm_checker #(
  parameter BLINK_HALF_CYC = 4
) (
  // Clock, reset, mode requests and engine reports
  input wire logic CLOCK, SYS_RST, RUN_REQ, STOP_REQ, STARTUP_DONE, CYCLE_END,
  // Engine controls
  input wire logic EXEC_ENABLE, TIMERS_RUN, IMAGE_REFRESH, CYCLE_SUPERVISE,
  // Status
  input wire logic [1:0] MODE,
  input wire logic OUTPUT_LOCK, RUN_LED, STOP_LED, WDOG_FAULT
);
  localparam int HB = BLINK_HALF_CYC + 1;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  property p_stop; MODE == 2'h0 |-> OUTPUT_LOCK && STOP_LED && !EXEC_ENABLE; endproperty
  a_stop: assert property (p_stop) else $error("stop outputs wrong");
  property p_start; MODE == 2'h0 && RUN_REQ && !STOP_REQ && !WDOG_FAULT |=> MODE == 2'h1; endproperty
  a_start: assert property (p_start) else $error("start-up not entered");
  property p_boot; MODE == 2'h1 |-> OUTPUT_LOCK && STOP_LED && !CYCLE_SUPERVISE; endproperty
  a_boot: assert property (p_boot) else $error("start-up outputs wrong");
  property p_done; MODE == 2'h1 && STARTUP_DONE && !STOP_REQ |=> MODE == 2'h2; endproperty
  a_done: assert property (p_done) else $error("run not entered");
  property p_blink; MODE == 2'h1 && $past(MODE) == 2'h0 |-> ##[1:HB] $changed(RUN_LED); endproperty
  a_blink: assert property (p_blink) else $error("run indicator not blinking");
  property p_run; MODE == 2'h2 |-> !OUTPUT_LOCK && !STOP_LED && TIMERS_RUN; endproperty
  a_run: assert property (p_run) else $error("run outputs wrong");
  property p_refresh; MODE == 2'h2 && CYCLE_END |=> IMAGE_REFRESH; endproperty
  a_refresh: assert property (p_refresh) else $error("image not refreshed");
  property p_hold; MODE == 2'h3 |-> OUTPUT_LOCK && STOP_LED && !TIMERS_RUN && !EXEC_ENABLE; endproperty
  a_hold: assert property (p_hold) else $error("hold outputs wrong");
  property p_halt; STOP_REQ |=> MODE == 2'h0; endproperty
  a_halt: assert property (p_halt) else $error("stop request ignored");
  c_hold: cover property (MODE == 2'h3);
  c_trip: cover property ($rose(WDOG_FAULT));
  c_run: cover property (MODE == 2'h2 && $past(MODE) == 2'h1);
endmodule // opm_checker
bind opm_mode_ctrl opm_checker #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_opm_chk (.*);
`default_nettype wire

// >>> opm_engine_model.sv
// Behavioural execution engine facing the mode sequencer.
// Start-up takes six cycles; a main cycle is eight statements.
`timescale 1ns/1ps
`default_nettype none
module opm_engine_model (
  // Clock, reset and grants
  input wire logic CLOCK, SYS_RST, STARTUP_ROUTINE_GO, COLD_START_ROUTINE_GO, MAIN_CYCLE_ROUTINE_GO, stall,
  // Progress
  output logic STARTUP_DONE, CYCLE_END,
  output logic [15:0] EXEC_PC
);
  logic [2:0] boot_cnt;
  wire logic boot = STARTUP_ROUTINE_GO | COLD_START_ROUTINE_GO;
  wire logic step = MAIN_CYCLE_ROUTINE_GO && !stall;
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      boot_cnt <= 3'h0;
      STARTUP_DONE <= 1'b0;
      CYCLE_END <= 1'b0;
      EXEC_PC <= 16'h0000;
    end else begin
      boot_cnt <= boot ? boot_cnt + 3'h1 : 3'h0;
      STARTUP_DONE <= boot && boot_cnt == 3'h5;
      CYCLE_END <= step && EXEC_PC[2:0] == 3'h7;
      // Stalling hangs the program for watchdog runs
      if (step)
        EXEC_PC <= {13'h0000, EXEC_PC[2:0] + 3'h1};
    end
  end
endmodule // opm_engine_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench: mode sequencer, engine model, tool stimulus.
// Shortened counts: blink minimum 50, watchdog 20, blink half period 4.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLOCK = 1'b0, SYS_RST = 1'b1, COLD_START_PRESENT = 1'b0, stall = 1'b0, BP_WR = 1'b0, BP_ACTIVE = 1'b0;
  logic [7:0] pl = 8'h00;
  logic [1:0] BP_IDX = 2'h0;
  logic [15:0] BP_ADDR = 16'h0000;
  wire logic RUN_REQ, STOP_REQ, MEM_RESET, PROJECT_RELOAD, CYCLE_TIMEOUT, STEP_REQ, RESUME_REQ, BP_CLR_ALL;
  wire logic STARTUP_DONE, CYCLE_END, STARTUP_ROUTINE_GO, COLD_START_ROUTINE_GO, MAIN_CYCLE_ROUTINE_GO;
  wire logic EXEC_ENABLE, TIMERS_RUN, IMAGE_REFRESH, CYCLE_SUPERVISE, STEP_GO, STEP_ALLOWED;
  wire logic OUTPUT_LOCK, RUN_LED, STOP_LED, WDOG_FAULT, CYCLE_FAULT;
  wire logic [1:0] BP_COUNT, MODE;
  wire logic [15:0] EXEC_PC;
  wire logic BP_SET = 1'b1;
  wire logic WDOG_KICK = CYCLE_END;
  int fails = 0;
  int samples_checked = 0;
  assign {BP_CLR_ALL, RESUME_REQ, STEP_REQ, CYCLE_TIMEOUT, PROJECT_RELOAD, MEM_RESET, STOP_REQ, RUN_REQ} = pl;
  opm_mode_ctrl #(.BLINK_MIN_CYC(50), .WDOG_CYC(20), .BLINK_HALF_CYC(4)) DUT (.*);
  opm_engine_model ENG (.*);
  initial forever #5 CLOCK = ~CLOCK;
  task tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task pulse(input logic [7:0] m);
    pl = m;
    tick(1);
    pl = 8'h00;
    tick(1);
  endtask
  task wait_mode(input logic [1:0] m);
    int i;
    for (i = 0; i < 300 && MODE !== m; i++)
      tick(1);
    if (MODE !== m) begin
      fails++;
      complete_run;
    end
  endtask
  task blink(input int n, output int t);
    logic p;
    t = 0;
    repeat (n) begin
      p = RUN_LED;
      tick(1);
      if (RUN_LED !== p)
        t++;
    end
  endtask
  task bp_write(input logic [1:0] i, input logic [15:0] a);
    BP_IDX = i;
    BP_ADDR = a;
    BP_WR = 1'b1;
    tick(1);
    BP_WR = 1'b0;
    tick(1);
  endtask
  task step_try(input logic g);
    pl = 8'h20;
    #1;
    chk(STEP_GO, g);
    tick(1);
    pl = 8'h00;
    tick(1);
  endtask
  task trip;
    stall = 1'b1;
    wait_mode(2'h0);
    stall = 1'b0;
    chk({WDOG_FAULT, OUTPUT_LOCK}, 16'h0003);
  endtask
  task t_stop;
    int t;
    pulse(8'h01);
    pulse(8'h10);
    chk({MODE, CYCLE_FAULT}, 16'h0002);
    pulse(8'h02);
    chk({MODE, OUTPUT_LOCK, STOP_LED, EXEC_ENABLE}, 16'h0006);
    blink(20, t);
    chk(t > 2, 16'h0001);
    tick(60);
    chk(RUN_LED, 16'h0000);
  endtask
  task t_startup;
    int t, i;
    pulse(8'h01);
    chk({MODE, OUTPUT_LOCK, STOP_LED, STARTUP_ROUTINE_GO, CYCLE_SUPERVISE}, 16'h001e);
    blink(40, t);
    chk(t > 5, 16'h0001);
    tick(20);
    chk({MODE, RUN_LED, STOP_LED, OUTPUT_LOCK, MAIN_CYCLE_ROUTINE_GO, TIMERS_RUN}, 16'h0053);
    chk({CYCLE_SUPERVISE, EXEC_ENABLE}, 16'h0003);
    for (i = 0; i < 10 && IMAGE_REFRESH !== 1'b1; i++)
      tick(1);
    chk(IMAGE_REFRESH, 16'h0001);
  endtask
  task t_bp;
    int t;
    bp_write(2'h0, 16'h0005);
    bp_write(2'h1, 16'h0100);
    chk({BP_COUNT, STEP_ALLOWED}, 16'h0005);
    BP_ACTIVE = 1'b1;
    wait_mode(2'h3);
    chk({STOP_LED, OUTPUT_LOCK, TIMERS_RUN, EXEC_ENABLE, MAIN_CYCLE_ROUTINE_GO}, 16'h0018);
    blink(12, t);
    chk(t > 1, 16'h0001);
    step_try(1'b1);
    chk(MODE, 16'h0002);
    bp_write(2'h2, 16'h0200);
    chk({BP_COUNT, STEP_ALLOWED}, 16'h0006);
    wait_mode(2'h3);
    step_try(1'b0);
    chk(MODE, 16'h0003);
    BP_ACTIVE = 1'b0;
    pulse(8'h40);
    chk(MODE, 16'h0002);
    pulse(8'h80);
    chk(BP_COUNT, 16'h0000);
  endtask
  task t_faults;
    int i;
    trip;
    pulse(8'h01);
    chk(MODE, 16'h0000);
    COLD_START_PRESENT = 1'b1;
    pulse(8'h01);
    chk({MODE, COLD_START_ROUTINE_GO}, 16'h0003);
    wait_mode(2'h2);
    COLD_START_PRESENT = 1'b0;
    for (i = 0; i < 2; i++) begin
      trip;
      pulse(i == 0 ? 8'h04 : 8'h08);
      chk(WDOG_FAULT, 16'h0000);
      pulse(8'h01);
      wait_mode(2'h2);
    end
    pulse(8'h10);
    chk({MODE, CYCLE_FAULT}, 16'h0001);
  endtask
  initial begin
    tick(12);
    SYS_RST = 1'b0;
    tick(1);
    chk({MODE, OUTPUT_LOCK, STOP_LED, RUN_LED, EXEC_ENABLE, BP_COUNT}, 16'h0030);
    t_stop;
    t_startup;
    t_bp;
    t_faults;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
